// ---- include/lcaps_map.svh ----
`ifndef LCAPS_MAP_SVH
`define LCAPS_MAP_SVH

`define LCAPS_ADDR_W 15
`define LCAPS_DATA_W 32
`define LCAPS_WORD_W 13
`define LCAPS_CFG_WORDS 64
`define LCAPS_FUNC_W 3
`define LCAPS_PDATA_W 10
`define LCAPS_PVAL_MSB 9
`define LCAPS_PVAL_LSB 2
`define LCAPS_PSCALE_MSB 1
`define LCAPS_PSCALE_LSB 0
`define LCAPS_CLK_MHZ 200
`define LCAPS_MAX_MHZ 250
`define LCAPS_ROM_MASK 32'h0000_0000
`define LCAPS_PWR_MASK 32'h0000_9F03
`define LCAPS_CFG_RESET 32'h0000_0000
`define LCAPS_PWR_WORD 13'h0011
`define LCAPS_AER_WORD 13'h0040

`endif

// ---- include/lcaps_pkg.sv ----
package lcaps_pkg;
  typedef enum logic [1:0] {LCAPS_IDLE, LCAPS_WAIT, LCAPS_DONE} lcaps_state_t;
  typedef enum logic [1:0] {LCAPS_MSG_NONE, LCAPS_MSG_TURNOFF, LCAPS_MSG_TOACK,
    LCAPS_MSG_PME} lcaps_msg_t;
endpackage : lcaps_pkg

// ---- include/lcaps_if.sv ----
`timescale 1ns/1ps
`include "lcaps_map.svh"
interface lcaps_if;
  logic [`LCAPS_ADDR_W-1:0] local_addr;
  logic [`LCAPS_DATA_W-1:0] local_wdata;
  logic [`LCAPS_DATA_W-1:0] local_rdata;
  logic local_rd_en;
  logic local_wr_en;
  logic local_ack;
  logic turnoff_request;
  logic turnoff_status_pulse;
  logic power_event_trigger;
  logic [`LCAPS_FUNC_W-1:0] power_event_function;
  logic [`LCAPS_PDATA_W-1:0] power_report_bus;
  logic aux_power_present;
  modport dev (input local_addr, input local_wdata, output local_rdata, input local_rd_en,
    input local_wr_en, output local_ack, input turnoff_request, output turnoff_status_pulse,
    input power_event_trigger, input power_event_function, input power_report_bus,
    input aux_power_present);
  modport app (output local_addr, output local_wdata, input local_rdata, output local_rd_en,
    output local_wr_en, input local_ack, output turnoff_request, input turnoff_status_pulse,
    output power_event_trigger, output power_event_function, output power_report_bus,
    output aux_power_present);
endinterface : lcaps_if

// ---- design/lcaps_dev.sv ----
`timescale 1ns/1ps
`include "lcaps_map.svh"
// Notes on behaviour
// - Port runs on application clock, up to 250MHz.
// - Byte address, low two bits ignored.
// - Each access moves one 32-bit word.
// - Same bit attributes as link accesses.
// - Link config access wins; local write waits.
// - Ack pulses on write done or read valid.
// - Local reads wait for no pending link request.
// - Single read/write, separate enables, request/ack.
// - Reads of any register always accepted.
// - Application writes only for header logging/debug.
// - Root port: no simultaneous local and link access.
// - Writes touch only writable bits.
// - Root port turn-off request sends turn-off message.
// - Endpoint app requests turn-off acknowledge message.
// - Root port pulses status one cycle on ack.
// - Endpoint pulses status one cycle on turn-off.
// - Endpoint power event edge sends PME message.
// - Low-power link woken before sending PME.
// - App drives function number with power event.
// - Power data: value 9:2, scale 1:0.
// - Power data only with aux-power bits zero; power_report follows power_report_bus whatever aux_power_present is.
// - Aux power input may be tied low.
module lcaps_dev (
  input wire logic clk,
  input wire logic rst_n,
  lcaps_if.dev lp,
  input wire logic root_port_mode,
  input wire logic cfg_tlp_pending,
  input wire logic [`LCAPS_WORD_W-1:0] cfg_tlp_addr,
  input wire logic [`LCAPS_DATA_W-1:0] cfg_tlp_wdata,
  input wire logic cfg_tlp_wr,
  output logic [`LCAPS_DATA_W-1:0] cfg_tlp_rdata,
  input wire logic link_rx_turnoff,
  input wire logic link_rx_toack,
  input wire logic link_low_power,
  input wire logic link_ready,
  output logic link_wake,
  output logic link_msg_valid,
  output lcaps_pkg::lcaps_msg_t link_msg,
  output logic [`LCAPS_FUNC_W-1:0] link_msg_func,
  output logic [`LCAPS_PDATA_W-1:0] power_report
);
  localparam int CLK_OK = (`LCAPS_CLK_MHZ <= `LCAPS_MAX_MHZ);

  typedef struct packed {
    lcaps_pkg::lcaps_state_t st;
    logic rd;
    logic [`LCAPS_WORD_W-1:0] word;
    logic [`LCAPS_DATA_W-1:0] wdata;
    logic [`LCAPS_DATA_W-1:0] rdata;
    logic ack;
    logic to_req_q;
    logic to_pulse;
    logic [2:0] ev_sync;
    logic pme_pend;
    logic [`LCAPS_FUNC_W-1:0] pme_func;
    logic wake;
    logic msg_valid;
    lcaps_pkg::lcaps_msg_t msg;
    logic [`LCAPS_FUNC_W-1:0] msg_func;
    logic [`LCAPS_PDATA_W-1:0] pdata;
    logic [`LCAPS_DATA_W-1:0] tlp_rdata;
  } lcaps_dev_state_t;

  lcaps_dev_state_t r;
  lcaps_dev_state_t next_r;
  logic [`LCAPS_DATA_W-1:0] cfg_mem [`LCAPS_CFG_WORDS];
  logic [`LCAPS_DATA_W-1:0] cfg_wmask [`LCAPS_CFG_WORDS];

  // Writable-bit mask per word; shared by link and local writes
  function automatic logic [`LCAPS_DATA_W-1:0] lcaps_mask(input logic [5:0] idx);
    if (idx == 6'(`LCAPS_PWR_WORD))
      lcaps_mask = `LCAPS_PWR_MASK;
    else if (idx < 6'h10)
      lcaps_mask = `LCAPS_ROM_MASK;
    else
      lcaps_mask = 32'hFFFF_FFFF;
  endfunction : lcaps_mask

  genvar gi;
  generate
    for (gi = 0; gi < `LCAPS_CFG_WORDS; gi++)
    begin : g_mask
      assign cfg_wmask[gi] = lcaps_mask(6'(gi));
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          cfg_mem[gi] <= `LCAPS_CFG_RESET;
        else if (cfg_tlp_pending && cfg_tlp_wr && cfg_tlp_addr[5:0] == 6'(gi))
          cfg_mem[gi] <= (cfg_mem[gi] & ~cfg_wmask[gi]) | (cfg_tlp_wdata & cfg_wmask[gi]);
        else if (r.st == lcaps_pkg::LCAPS_WAIT && !r.rd && !cfg_tlp_pending
                 && r.word[5:0] == 6'(gi))
          cfg_mem[gi] <= (cfg_mem[gi] & ~cfg_wmask[gi]) | (r.wdata & cfg_wmask[gi]);
      end
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.to_pulse = 1'b0;
    next_r.msg_valid = 1'b0;
    next_r.tlp_rdata = cfg_mem[cfg_tlp_addr[5:0]];
    next_r.pdata = lp.power_report_bus;
    case (r.st)
      lcaps_pkg::LCAPS_IDLE:
      begin
        if (lp.local_rd_en || lp.local_wr_en)
        begin
          next_r.st = lcaps_pkg::LCAPS_WAIT;
          next_r.rd = lp.local_rd_en;
          next_r.word = lp.local_addr[`LCAPS_ADDR_W-1:2];
          next_r.wdata = lp.local_wdata;
        end
      end
      lcaps_pkg::LCAPS_WAIT:
      begin
        if (!cfg_tlp_pending)
        begin
          next_r.st = lcaps_pkg::LCAPS_DONE;
          if (r.rd)
            next_r.rdata = cfg_mem[r.word[5:0]];
          next_r.ack = 1'b1;
        end
      end
      lcaps_pkg::LCAPS_DONE:
        next_r.st = lcaps_pkg::LCAPS_IDLE;
      default:
        next_r.st = lcaps_pkg::LCAPS_IDLE;
    endcase

    next_r.to_req_q = lp.turnoff_request;
    if (lp.turnoff_request && !r.to_req_q)
    begin
      next_r.msg_valid = 1'b1;
      next_r.msg = root_port_mode ? lcaps_pkg::LCAPS_MSG_TURNOFF
                                  : lcaps_pkg::LCAPS_MSG_TOACK;
    end
    next_r.to_pulse = root_port_mode ? link_rx_toack : link_rx_turnoff;

    next_r.wake = r.pme_pend && link_low_power;
    if (r.pme_pend && !link_low_power && link_ready && !next_r.msg_valid)
    begin
      next_r.pme_pend = 1'b0;
      next_r.msg_valid = 1'b1;
      next_r.msg = lcaps_pkg::LCAPS_MSG_PME;
      next_r.msg_func = r.pme_func;
    end
    // New event after the send, so an edge in the send cycle stays pending
    next_r.ev_sync = {r.ev_sync[1:0], lp.power_event_trigger};
    if (!root_port_mode && r.ev_sync[2:1] == 2'b01)
    begin
      next_r.pme_pend = 1'b1;
      next_r.pme_func = lp.power_event_function;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign lp.local_rdata = r.rdata;
  assign lp.local_ack = r.ack;
  assign lp.turnoff_status_pulse = r.to_pulse;
  assign link_wake = r.wake;
  assign link_msg_valid = r.msg_valid;
  assign link_msg = r.msg;
  assign link_msg_func = r.msg_func;
  assign power_report = r.pdata;
  assign cfg_tlp_rdata = r.tlp_rdata;
endmodule : lcaps_dev

// ---- design/lcaps_app.sv ----
`timescale 1ns/1ps
`include "lcaps_map.svh"
module lcaps_app (
  input wire logic clk,
  input wire logic rst_n,
  lcaps_if.app lp,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`LCAPS_ADDR_W-1:0] req_addr,
  input wire logic [`LCAPS_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [`LCAPS_DATA_W-1:0] resp_rdata,
  input wire logic turnoff_cmd,
  output logic turnoff_seen,
  input wire logic pme_cmd,
  input wire logic [`LCAPS_FUNC_W-1:0] pme_func,
  input wire logic [`LCAPS_PDATA_W-1:0] power_value
);
  typedef struct packed {
    logic busy;
    logic rd_en;
    logic wr_en;
    logic [`LCAPS_ADDR_W-1:0] addr;
    logic [`LCAPS_DATA_W-1:0] wdata;
    logic rvalid;
    logic [`LCAPS_DATA_W-1:0] rdata;
    logic to_req;
    logic to_seen;
    logic ev;
    logic [`LCAPS_FUNC_W-1:0] func;
    logic [`LCAPS_PDATA_W-1:0] pdata;
  } lcaps_app_state_t;

  lcaps_app_state_t r;
  lcaps_app_state_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.rd_en = 1'b0;
    next_r.wr_en = 1'b0;
    next_r.rvalid = 1'b0;
    next_r.to_seen = lp.turnoff_status_pulse;
    next_r.to_req = turnoff_cmd;
    next_r.ev = pme_cmd;
    next_r.pdata = power_value;
    if (pme_cmd)
      next_r.func = pme_func;
    if (!r.busy && req_valid)
    begin
      next_r.busy = 1'b1;
      next_r.rd_en = !req_write;
      next_r.wr_en = req_write;
      next_r.addr = req_addr;
      next_r.wdata = req_wdata;
    end
    else if (r.busy && lp.local_ack)
    begin
      next_r.busy = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = lp.local_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign lp.local_rd_en = r.rd_en;
  assign lp.local_wr_en = r.wr_en;
  assign lp.local_addr = r.addr;
  assign lp.local_wdata = r.wdata;
  assign lp.turnoff_request = r.to_req;
  assign lp.power_event_trigger = r.ev;
  assign lp.power_event_function = r.func;
  assign lp.power_report_bus = r.pdata;
  assign lp.aux_power_present = 1'b0;
  assign req_ready = !r.busy;
  assign resp_valid = r.rvalid;
  assign resp_rdata = r.rdata;
  assign turnoff_seen = r.to_seen;
endmodule : lcaps_app

// ---- sim/lcaps_properties.sv ----
`timescale 1ns/1ps
module lcaps_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] local_rdata,
  input wire logic local_rd_en,
  input wire logic local_wr_en,
  input wire logic local_ack,
  input wire logic turnoff_status_pulse,
  input wire logic aux_power_present
);
  logic req;
  assign req = local_rd_en || local_wr_en;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_ack_one_cycle: assert property (local_ack |=> !local_ack)
    else $error("ack too long");
  chk_data_with_ack: assert property ($changed(local_rdata) |-> local_ack)
    else $error("rdata moved without ack");
  chk_no_early_ack: assert property (req |=> !local_ack)
    else $error("ack too early");
  chk_status_one_cycle: assert property (turnoff_status_pulse |=> !turnoff_status_pulse)
    else $error("status too long");
  chk_single_enable: assert property (!(local_rd_en && local_wr_en))
    else $error("both enables");
  chk_request_gap: assert property (req |=> (!req) [*2])
    else $error("requests too close");
  chk_no_req_on_ack: assert property (local_ack |-> !req)
    else $error("request during ack");
  chk_aux_tied_low: assert property (!aux_power_present)
    else $error("aux power high");
endmodule : lcaps_properties

// ---- sim/local_config_access_and_pm_sideband_tb.sv ----
`timescale 1ns/1ps
module local_config_access_and_pm_sideband_tb;
  int error_cnt = 0, checks_done = 0, i;
  logic clk = 1'b0, rst_n, req_valid, req_write, turnoff_cmd, pme_cmd, root_port_mode;
  logic cfg_tlp_pending, cfg_tlp_wr, link_rx_turnoff, link_rx_toack, link_low_power, link_ready;
  logic req_ready, resp_valid, turnoff_seen, link_wake, link_msg_valid;
  logic [14:0] req_addr;
  logic [12:0] cfg_tlp_addr;
  logic [31:0] req_wdata, cfg_tlp_wdata, resp_rdata, rd, cfg_tlp_rdata;
  logic [2:0] pme_func, link_msg_func;
  logic [9:0] power_value, power_report;
  lcaps_pkg::lcaps_msg_t link_msg;
  lcaps_if lp();
  lcaps_dev lcaps_dev_inst (.clk, .rst_n, .lp, .root_port_mode, .cfg_tlp_pending, .cfg_tlp_addr,
    .cfg_tlp_wdata, .cfg_tlp_wr, .cfg_tlp_rdata, .link_rx_turnoff, .link_rx_toack,
    .link_low_power, .link_ready, .link_wake, .link_msg_valid, .link_msg, .link_msg_func,
    .power_report);
  lcaps_app lcaps_app_inst (.clk, .rst_n, .lp, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .resp_valid, .resp_rdata, .turnoff_cmd, .turnoff_seen, .pme_cmd, .pme_func,
    .power_value);
  lcaps_properties lcaps_properties_inst (.clk, .rst_n, .local_rdata(lp.local_rdata),
    .local_rd_en(lp.local_rd_en), .local_wr_en(lp.local_wr_en), .local_ack(lp.local_ack),
    .turnoff_status_pulse(lp.turnoff_status_pulse), .aux_power_present(lp.aux_power_present));
  initial forever #2.5 clk = ~clk;
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wait_high(ref logic s);
    for (i = 0; i < 12 && s !== 1'b1; i++) step;
  endtask : wait_high
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Link stays busy for hold cycles after the request is taken; its write data flips each cycle
  task automatic xfer(input logic wr, input logic [14:0] a, input logic [31:0] d, input int hold);
    wait_high(req_ready);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    step;
    req_valid = 1'b0;
    repeat (hold)
    begin
      step;
      cfg_tlp_wdata = ~cfg_tlp_wdata;
    end
    cfg_tlp_pending = 1'b0;
    wait_high(resp_valid);
    chk("resp_valid", 1, resp_valid);
    rd = resp_rdata;
    step;
  endtask : xfer
  task automatic t_regs;
    xfer(1'b1, 15'h0014, 32'hFFFF_FFFF, 0);
    xfer(1'b0, 15'h0014, 32'h0000_0000, 0);
    chk("read-only word", 32'h0000_0000, rd);
    xfer(1'b1, 15'h0044, 32'hFFFF_FFFF, 0);
    xfer(1'b0, 15'h0044, 32'h0000_0000, 0);
    chk("masked word", 32'h0000_9F03, rd);
  endtask : t_regs
  task automatic t_prio;
    cfg_tlp_pending = 1'b1;
    cfg_tlp_wr = 1'b1;
    cfg_tlp_addr = 13'h0020;
    cfg_tlp_wdata = 32'h1111_1111;
    xfer(1'b1, 15'h0083, 32'h2222_2222, 6);
    xfer(1'b0, 15'h0080, 32'h0000_0000, 0);
    chk("held write", 32'h2222_2222, rd);
    cfg_tlp_pending = 1'b1;
    cfg_tlp_addr = 13'h0021;
    xfer(1'b0, 15'h0084, 32'h0000_0000, 6);
    chk("held read", 32'hEEEE_EEEE, rd);
    chk("link read data", 32'hEEEE_EEEE, cfg_tlp_rdata);
    cfg_tlp_wr = 1'b0;
  endtask : t_prio
  task automatic t_turnoff;
    for (int m = 0; m < 2; m++)
    begin
      root_port_mode = m[0];
      turnoff_cmd = 1'b1;
      wait_high(link_msg_valid);
      if (m) chk("msg", lcaps_pkg::LCAPS_MSG_TURNOFF, link_msg);
      if (!m) chk("msg", lcaps_pkg::LCAPS_MSG_TOACK, link_msg);
      turnoff_cmd = 1'b0;
      link_rx_toack = m[0];
      link_rx_turnoff = !m[0];
      step;
      link_rx_toack = 1'b0;
      link_rx_turnoff = 1'b0;
      wait_high(turnoff_seen);
      chk("turnoff_seen", 1, turnoff_seen);
    end
  endtask : t_turnoff
  task automatic t_pme;
    root_port_mode = 1'b0;
    link_low_power = 1'b1;
    link_ready = 1'b1;
    pme_func = 3'h5;
    power_value = 10'h1CA;
    pme_cmd = 1'b1;
    wait_high(link_wake);
    chk("link_wake", 1, link_wake);
    chk("msg in low power", lcaps_pkg::LCAPS_MSG_TURNOFF, link_msg);
    link_low_power = 1'b0;
    link_ready = 1'b1;
    wait_high(link_msg_valid);
    chk("pme msg", lcaps_pkg::LCAPS_MSG_PME, link_msg);
    chk("pme func", 3'h5, link_msg_func);
    chk("power data", 10'h1CA, power_report);
    pme_cmd = 1'b0;
  endtask : t_pme
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    #20000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    {rst_n, req_valid, req_write, req_addr, req_wdata, turnoff_cmd, pme_cmd, pme_func} = '0;
    {power_value, root_port_mode, cfg_tlp_pending, cfg_tlp_addr, cfg_tlp_wdata, cfg_tlp_wr} = '0;
    {link_rx_turnoff, link_rx_toack, link_low_power} = '0;
    link_ready = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_prio();
    t_turnoff();
    t_pme();
    print_verdict();
  end
endmodule : local_config_access_and_pm_sideband_tb
